//--- bench/core_model.sv
// Core model: counts instruction ticks that reach the CPU.
// Assumes run and tick come from the clock control block.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic cpu_run,
  input wire logic cpu_tick,
  output logic [15:0] executed
);
  // Only a tick with the clock applied executes an instruction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      executed <= 16'h0000;
    end else if (cpu_run && cpu_tick) begin
      executed <= executed + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- bench/power_save_clock_gating_tb.sv
// Testbench: idle, slowdown and module gates of the clock control block.
// Assumes the package, the design and the core model compile first.
`timescale 1ns/100ps
`default_nettype none
module power_save_clock_gating_tb;
  // Module 7 is absent, so it must never be enabled
  localparam logic [7:0] present = 8'h7f;
  logic clock = 1'b0;
  logic rst = 1'b1;
  power_save_pkg::core_events_t ev = '0;
  logic [15:0] div_data = 16'h0000;
  logic div_wr = 1'b0;
  logic [7:0] gate_data = 8'h00;
  logic gate_wr = 1'b0;
  logic [15:0] div_reg;
  power_save_pkg::core_controls_t ctl;
  logic tick;
  logic [7:0] clk_en;
  logic [7:0] acc_en;
  logic [7:0] gate;
  logic [15:0] executed;
  logic [15:0] cnt;
  logic [15:0] snap;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  power_save_clock_gating #(
    .num_modules(8),
    .modules_present(present)
  ) power_save_clock_gating_inst (
    .clock(clock),
    .rst(rst),
    .events(ev),
    .divider_write_data(div_data),
    .divider_write(div_wr),
    .gate_write_data(gate_data),
    .gate_write(gate_wr),
    .clock_divider_register(div_reg),
    .controls(ctl),
    .cpu_clock_pulse(tick),
    .module_clock_enable(clk_en),
    .module_access_enable(acc_en),
    .module_clock_gate(gate)
  );
  core_model core_model_inst (
    .clock(clock),
    .rst(rst),
    .cpu_run(ctl.cpu_clock_enable),
    .cpu_tick(tick),
    .executed(executed)
  );
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_div(input logic [15:0] d);
    div_data = d;
    div_wr = 1'b1;
    step();
    div_wr = 1'b0;
  endtask
  task automatic wr_gate(input logic [7:0] d);
    gate_data = d;
    gate_wr = 1'b1;
    step();
    gate_wr = 1'b0;
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run is about 2100 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      wrap_up();
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    int i;
    step(10);
    rst = 1'b0;
    step();
    check(div_reg, 16'h0000);
    check({8'h00, clk_en}, {8'h00, present});
    check({8'h00, gate}, 16'h0000);
    check(ctl.cpu_clock_enable, 1'b1);
    // A window of 256 cycles is a whole number of ticks at any ratio
    for (int n = 0; n < 8; n++) begin
      wr_div({1'b0, n[2:0], 1'b1, 11'h000});
      // The write edge still ticks at the old ratio, so skip it
      step();
      cnt = 16'h0000;
      repeat (256) begin
        cnt = cnt + {15'h0000, tick};
        step();
      end
      check(cnt, 16'h0100 >> n);
      check({8'h00, clk_en}, {8'h00, present});
    end
    for (int k = 0; k < 2; k++) begin
      wr_div(k == 0 ? 16'hb800 : 16'h3800);
      ev.irq_pending = 1'b1;
      step();
      ev.irq_pending = 1'b0;
      step();
      check(div_reg, k == 0 ? 16'hb000 : 16'h3800);
    end
    // A write in the same cycle as the interrupt wins over the clear
    ev.irq_pending = 1'b1;
    wr_div(16'h8800);
    check(div_reg, 16'h8800);
    step();
    ev.irq_pending = 1'b0;
    check(div_reg, 16'h8000);
    wr_div(16'h0000);
    // Wake by interrupt coincident with entry, by time-out, by reset
    for (int k = 0; k < 3; k++) begin
      ev.watchdog_enabled = (k == 0);
      ev.clock_fail_enabled = (k == 1);
      ev.irq_pending = (k == 0);
      ev.enter_idle = 1'b1;
      step();
      ev.enter_idle = 1'b0;
      snap = executed;
      check(ctl.in_idle, 1'b1);
      check(ctl.cpu_clock_enable, 1'b0);
      check(ctl.watchdog_clear, 1'b1);
      check(ctl.low_power_rc_run, k < 2);
      check({8'h00, clk_en}, {8'h00, present});
      if (k == 2) begin
        // Two quiet cycles show idle holds with no wake event
        step(2);
        check(ctl.in_idle, 1'b1);
        check(executed, snap);
        rst = 1'b1;
        step();
        check(ctl.in_idle, 1'b0);
        rst = 1'b0;
      end else begin
        ev.watchdog_timeout = (k == 1);
        i = 0;
        step();
        ev.watchdog_timeout = 1'b0;
        while (ctl.resume !== 1'b1 && i < 8) begin
          step();
          i++;
        end
        check(i < 4, 1'b1);
        check(executed, snap);
        ev.irq_pending = 1'b0;
      end
      step();
      check(ctl.cpu_clock_enable, 1'b1);
      check(ctl.in_idle, 1'b0);
    end
    wr_gate(8'h81);
    check({8'h00, gate}, 16'h0081);
    check({8'h00, clk_en}, {8'h00, present});
    step();
    check({8'h00, clk_en}, 16'h007e);
    check({8'h00, acc_en}, 16'h007e);
    wr_gate(8'h00);
    check({8'h00, clk_en}, 16'h007e);
    step();
    check({8'h00, clk_en}, {8'h00, present});
    wrap_up();
  end
endmodule
`default_nettype wire

//--- hw/power_save_clock_gating.sv
// Power-save clock control: idle, CPU slowdown and per-module clock gates.
// Assumes all inputs are synchronous to clock and the core samples
// cpu_clock_enable as a clock gate enable.
//
// Contract
// R01 - Idle withholds CPU clock so nothing executes.
// R02 - Entering idle clears the watchdog count.
// R03 - System clock and enabled module clocks keep running in idle.
// R04 - Low-power RC runs in idle if watchdog or fail monitor enabled.
// R05 - Idle exits on enabled interrupt, reset or watchdog time-out.
// R06 - On wake CPU clock returns; execution resumes 2 to 4 cycles later.
// R07 - Interrupt during power-save instruction deferred until idle entered.
// R08 - Slowdown keeps system clock and peripherals at full speed.
// R09 - Slowdown active while enable bit 11 is set.
// R10 - Ratio bits 14:12 select 1:1 to 1:128, default 1:1.
// R11 - With bit 15 set, an interrupt restores full CPU speed.
// R12 - With bit 15 clear, interrupts leave slowdown untouched.
// R13 - Slowed CPU clock stays aligned to peripheral clock.
// R14 - Set gate bit stops all clocks of that module.
// R15 - Gated module ignores writes and returns invalid reads.
// R16 - Module enabled only if gate clear and module present.
// R17 - Gate bits of present modules clear after reset.
// R18 - Gate change takes effect one instruction cycle after write.
// R19 - Ratio codes 0..7 mean divisors 1,2,4,...,128.
`timescale 1ns/100ps
`default_nettype none

module power_save_clock_gating #(
  parameter int num_modules = power_save_pkg::num_modules_default,
  parameter logic [num_modules-1:0] modules_present = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire power_save_pkg::core_events_t events,
  input wire logic [15:0] divider_write_data,
  input wire logic divider_write,
  input wire logic [num_modules-1:0] gate_write_data,
  input wire logic gate_write,
  output logic [15:0] clock_divider_register,
  output power_save_pkg::core_controls_t controls,
  output logic cpu_clock_pulse,
  output logic [num_modules-1:0] module_clock_enable,
  output logic [num_modules-1:0] module_access_enable,
  output logic [num_modules-1:0] module_clock_gate
);

  // ********************************************************************
  // Parameter checks
  // ********************************************************************
  // Gate bits fit one word; the resume count must suit its 3-bit counter
  if (num_modules < 1 || num_modules > 16) begin : g_bad_modules
    $error("num_modules must be 1 to 16");
  end
  if (power_save_pkg::resume_cycles < 2 ||
      power_save_pkg::resume_cycles > 4) begin : g_bad_resume
    $error("resume_cycles must be 2 to 4");
  end

  // ********************************************************************
  // Idle state machine
  // ********************************************************************
  power_save_pkg::power_state_t state;
  logic [2:0] resume_count;
  logic wake;

  // Interrupt raised while entering is only looked at once in idle
  assign wake = events.irq_pending || events.watchdog_timeout; // see R05

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= power_save_pkg::run_st;
      resume_count <= 3'h0;
    end else begin
      case (state)
        power_save_pkg::run_st: begin
          if (events.enter_idle) begin
            state <= power_save_pkg::idle_st; // see R07
          end
        end
        power_save_pkg::idle_st: begin
          if (wake) begin
            state <= power_save_pkg::resume_st; // see R05
            resume_count <= 3'h0;
          end
        end
        power_save_pkg::resume_st: begin
          resume_count <= resume_count + 3'h1;
          if (resume_count == 3'(power_save_pkg::resume_cycles - 1)) begin
            state <= power_save_pkg::run_st; // see R06
          end
        end
        default: begin
          state <= power_save_pkg::run_st;
        end
      endcase
    end
  end

  // ********************************************************************
  // Clock divider register and slowdown
  // ********************************************************************
  logic slowdown;
  logic [6:0] div_count;
  logic [6:0] div_mask;
  logic [2:0] ratio;

  assign slowdown = clock_divider_register[power_save_pkg::slowdown_enable_bit];
  assign ratio = clock_divider_register[power_save_pkg::ratio_msb:
                                        power_save_pkg::ratio_lsb];
  // Divisor is 2**code, so a mask of code ones wraps the counter
  assign div_mask = 7'((8'h01 << ratio) - 8'h01); // see R19

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_divider_register <= power_save_pkg::clock_divider_reset;
    end else if (divider_write) begin
      clock_divider_register <= divider_write_data; // see R09
    end else if (events.irq_pending &&
                 clock_divider_register[
                   power_save_pkg::full_speed_on_interrupt_bit]) begin
      // Clearing the enable rather than the ratio keeps the setting
      clock_divider_register[power_save_pkg::slowdown_enable_bit]
        <= 1'b0; // see R11
    end
    // Without the bit, interrupts change nothing here; see R12
  end

  // Counter runs off the system clock, so CPU edges land on peripheral edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count <= 7'h00;
    end else if (!slowdown || (div_count & div_mask) == div_mask) begin
      div_count <= 7'h00; // see R13
    end else begin
      div_count <= div_count + 7'h01; // see R10
    end
  end

  logic next_cpu_pulse;
  assign next_cpu_pulse = (state == power_save_pkg::run_st) &&
                          !events.enter_idle &&
                          (!slowdown || div_count == 7'h00); // see R08

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_clock_pulse <= 1'b0;
      controls <= '0;
    end else begin
      cpu_clock_pulse <= next_cpu_pulse;
      controls.cpu_clock_enable <= (state == power_save_pkg::run_st) &&
                                   !events.enter_idle; // see R01
      controls.watchdog_clear <= (state == power_save_pkg::run_st) &&
                                 events.enter_idle; // see R02
      controls.in_idle <= (state != power_save_pkg::run_st) ||
                          events.enter_idle;
      controls.resume <= (state == power_save_pkg::resume_st) &&
        (resume_count == 3'(power_save_pkg::resume_cycles - 1)); // see R06
      controls.low_power_rc_run <= events.watchdog_enabled ||
                                   events.clock_fail_enabled; // see R04
    end
  end

  // ********************************************************************
  // Module clock gates
  // ********************************************************************
  logic [num_modules-1:0] next_enable;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      module_clock_gate <= '0; // see R17
    end else if (gate_write) begin
      module_clock_gate <= gate_write_data;
    end
  end

  // Idle does not touch module clocks; see R03
  assign next_enable = ~module_clock_gate & modules_present; // see R16

  // One register stage gives the one-cycle latency after the write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      module_clock_enable <= '0;
      module_access_enable <= '0;
    end else begin
      module_clock_enable <= next_enable; // see R14 R18
      module_access_enable <= next_enable; // see R15
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence s_enter;
    state == power_save_pkg::run_st && events.enter_idle;
  endsequence

  sequence s_wake;
    state == power_save_pkg::idle_st && wake;
  endsequence

  property p_idle_no_clock;
    @(posedge clock) disable iff (rst)
    s_enter |=> !controls.cpu_clock_enable && !cpu_clock_pulse;
  endproperty
  a_idle_no_clock: assert property (p_idle_no_clock) // see R01
    else $error("CPU clock ran on idle entry");

  property p_watchdog_clear;
    @(posedge clock) disable iff (rst)
    s_enter |=> controls.watchdog_clear;
  endproperty
  a_watchdog_clear: assert property (p_watchdog_clear) // see R02
    else $error("Watchdog not cleared on idle entry");

  property p_rc_watchdog;
    @(posedge clock) disable iff (rst)
    events.watchdog_enabled |=> controls.low_power_rc_run;
  endproperty
  a_rc_watchdog: assert property (p_rc_watchdog) // see R04
    else $error("Low-power RC stopped with watchdog enabled");

  property p_wake;
    @(posedge clock) disable iff (rst)
    s_wake |=> ##1 ##[0:2]
      (controls.resume && !controls.cpu_clock_enable);
  endproperty
  a_wake: assert property (p_wake) // see R05
    else $error("Idle wake did not resume in time");

  property p_resume_clock;
    @(posedge clock) disable iff (rst)
    controls.resume && !events.enter_idle |=> controls.cpu_clock_enable;
  endproperty
  a_resume_clock: assert property (p_resume_clock) // see R06
    else $error("CPU clock not restored after resume");

  property p_return_full;
    @(posedge clock) disable iff (rst)
    (events.irq_pending && !divider_write &&
     clock_divider_register[power_save_pkg::full_speed_on_interrupt_bit])
    |=> !slowdown;
  endproperty
  a_return_full: assert property (p_return_full) // see R11
    else $error("Interrupt did not restore full speed");

  property p_no_return;
    @(posedge clock) disable iff (rst)
    (!divider_write &&
     !clock_divider_register[power_save_pkg::full_speed_on_interrupt_bit])
    |=> $stable(clock_divider_register);
  endproperty
  a_no_return: assert property (p_no_return) // see R12
    else $error("Divider changed without a write");

  property p_gate_delay;
    @(posedge clock) disable iff (rst)
    gate_write ##1 !gate_write |=>
      module_clock_enable == (~$past(gate_write_data, 2) & modules_present);
  endproperty
  a_gate_delay: assert property (p_gate_delay) // see R18
    else $error("Module gate change latency wrong");

  property p_present;
    @(posedge clock) disable iff (rst)
    (module_clock_enable & ~modules_present) == '0;
  endproperty
  a_present: assert property (p_present) // see R16
    else $error("Absent module enabled");

  property p_idle_stops;
    @(posedge clock) disable iff (rst)
    state != power_save_pkg::run_st |->
      !cpu_clock_pulse && !controls.cpu_clock_enable;
  endproperty
  a_idle_stops: assert property (p_idle_stops) // see R01
    else $error("CPU clock ran outside run state");

  property p_clear_pulse;
    @(posedge clock) disable iff (rst)
    controls.watchdog_clear |=> !controls.watchdog_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) // see R02
    else $error("Watchdog clear held for more than a cycle");

  property p_idle_modules;
    @(posedge clock) disable iff (rst)
    state != power_save_pkg::run_st |=>
      module_clock_enable == (~$past(module_clock_gate) & modules_present);
  endproperty
  a_idle_modules: assert property (p_idle_modules) // see R03
    else $error("Module clocks changed by idle");

  property p_rc_fail_monitor;
    @(posedge clock) disable iff (rst)
    events.clock_fail_enabled |=> controls.low_power_rc_run;
  endproperty
  a_rc_fail_monitor: assert property (p_rc_fail_monitor) // see R04
    else $error("Low-power RC stopped with fail monitor enabled");

  property p_idle_stay;
    @(posedge clock) disable iff (rst)
    state == power_save_pkg::idle_st && !wake |=>
      state == power_save_pkg::idle_st && controls.in_idle;
  endproperty
  a_idle_stay: assert property (p_idle_stay) // see R05
    else $error("Idle left without a wake event");

  property p_entry_completes;
    @(posedge clock) disable iff (rst)
    s_enter ##0 events.irq_pending |=> state == power_save_pkg::idle_st;
  endproperty
  a_entry_completes: assert property (p_entry_completes) // see R07
    else $error("Interrupt cut idle entry short");

  property p_slow_modules;
    @(posedge clock) disable iff (rst)
    slowdown |=>
      module_clock_enable == (~$past(module_clock_gate) & modules_present);
  endproperty
  a_slow_modules: assert property (p_slow_modules) // see R08
    else $error("Module clocks changed by slowdown");

  property p_div_write;
    @(posedge clock) disable iff (rst)
    divider_write |=> clock_divider_register == $past(divider_write_data);
  endproperty
  a_div_write: assert property (p_div_write) // see R09
    else $error("Divider write did not land");

  property p_slow_gap;
    @(posedge clock) disable iff (rst)
    slowdown && div_count != 7'h00 |=> !cpu_clock_pulse;
  endproperty
  a_slow_gap: assert property (p_slow_gap) // see R10
    else $error("CPU tick between divider wraps");

  property p_full_speed;
    @(posedge clock) disable iff (rst)
    state == power_save_pkg::run_st && !events.enter_idle && !slowdown
    |=> cpu_clock_pulse;
  endproperty
  a_full_speed: assert property (p_full_speed) // see R11
    else $error("CPU tick missing at full speed");

  property p_gate_readback;
    @(posedge clock) disable iff (rst)
    gate_write |=> module_clock_gate == $past(gate_write_data);
  endproperty
  a_gate_readback: assert property (p_gate_readback) // see R14
    else $error("Gate bits did not take the write");

  property p_access_match;
    @(posedge clock) disable iff (rst)
    module_access_enable == module_clock_enable;
  endproperty
  a_access_match: assert property (p_access_match) // see R15
    else $error("Register access enable differs from clock enable");

endmodule

`default_nettype wire

//--- hw/power_save_pkg.sv
// Constants and carrier types for the power-save clock control block.
// Assumes a single system clock; all users refer to names with pkg:: scope.
package power_save_pkg;

  // ********************************************************************
  // Clock divider register fields
  // ********************************************************************
  localparam int slowdown_enable_bit = 11;
  localparam int ratio_lsb = 12;
  localparam int ratio_msb = 14;
  localparam int full_speed_on_interrupt_bit = 15;
  localparam logic [15:0] clock_divider_reset = 16'h0000;
  localparam logic [2:0] ratio_reset = 3'h0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  // Clocks from wake until the core is told to resume (2 to 4 allowed)
  localparam int resume_cycles = 2;
  // Module gate change latency, one instruction cycle
  localparam int gate_delay_cycles = 1;
  localparam int num_modules_default = 16;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    run_st,
    idle_st,
    resume_st
  } power_state_t;

  typedef struct packed {
    logic enter_idle;
    logic irq_pending;
    logic watchdog_timeout;
    logic watchdog_enabled;
    logic clock_fail_enabled;
  } core_events_t;

  typedef struct packed {
    logic cpu_clock_enable;
    logic resume;
    logic watchdog_clear;
    logic low_power_rc_run;
    logic in_idle;
  } core_controls_t;

endpackage
